// ===== shared/tws_pkg.sv
package tws_pkg;
    // Clock period of the system clock
    localparam int CLK_NS = 100;
    // Quarter of one serial bit, least time
    localparam int T_QTR_NS = 2500;
    localparam int QTR_CYC = (T_QTR_NS + CLK_NS - 1) / CLK_NS;
    // Idle time before the bus counts as free
    localparam int T_FREE_NS = 4700;
    localparam int FREE_CYC = (T_FREE_NS + CLK_NS - 1) / CLK_NS;
    // Register word offsets
    localparam logic [2:0] OFS_CTRL = 3'h0;
    localparam logic [2:0] OFS_STAT = 3'h1;
    localparam logic [2:0] OFS_DATA = 3'h2;
    localparam logic [2:0] OFS_IST = 3'h3;
    localparam logic [2:0] OFS_IMASK = 3'h4;
    // Control bit positions
    localparam int B_FLAG = 7;
    localparam int B_ACKEN = 6;
    localparam int B_BEGIN = 5;
    localparam int B_END = 4;
    localparam int B_WCOL = 3;
    localparam int B_EN = 2;
    localparam int B_IRQEN = 0;
    // Interrupt status bit positions
    localparam int E_FLAG = 0;
    localparam int E_WCOL = 1;
    localparam int E_ARB = 2;
    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_CODE = 8'hf8;
    localparam logic [7:0] RST_DATA = 8'hff;
    // Status codes
    localparam logic [7:0] C_START = 8'h08;
    localparam logic [7:0] C_RSTART = 8'h10;
    localparam logic [7:0] C_AW_ACK = 8'h18;
    localparam logic [7:0] C_AW_NACK = 8'h20;
    localparam logic [7:0] C_DT_ACK = 8'h28;
    localparam logic [7:0] C_DT_NACK = 8'h30;
    localparam logic [7:0] C_ARB = 8'h38;
    localparam logic [7:0] C_AR_ACK = 8'h40;
    localparam logic [7:0] C_AR_NACK = 8'h48;
    localparam logic [7:0] C_DR_ACK = 8'h50;
    localparam logic [7:0] C_DR_NACK = 8'h58;
    // Sequencer states, Gray along the usual path
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_WAIT = 3'h1,
        S_START = 3'h3,
        S_HOLD = 3'h2,
        S_BIT = 3'h6,
        S_STOP = 3'h7
    } tws_state_t;
endpackage : tws_pkg

// ===== src/tws_master.sv
// Added by the designer: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - Transmit results report 18, 20, 28, 30
// - Clear with no conditions sends loaded byte, or receives one in read mode
// - Begin request alone gives repeated start
// - End request alone stops, then self-clears
// - Both requests: stop, start, end bit cleared
// - Arbitration loss reports 38, releases bus
// - After loss, begin request waits free bus
// - Enable plus begin request starts on free bus
// - Start sent sets flag, code 08
// - Read address result reports 38, 40, 48
// - Received byte readable when flag set
// - Repeated start reports 10, keeps bus
// - Writing flag one clears it, resumes transfer
// - Data write while flag low sets collision
// - Receive acks by the acknowledge enable bit
module tws_master (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset
    input wire logic [2:0] address, // Word index
    input wire logic read, // Read request
    input wire logic write, // Write request
    input wire logic [7:0] writedata, // Write data
    output logic [7:0] readdata, // Read data
    output logic waitrequest, // Stall the master
    output logic irq, // Interrupt level
    input wire logic scl_i, // Clock line level
    output logic scl_o, // Clock drive value
    output logic scl_oe, // Clock pulled low
    input wire logic sda_i, // Data line level
    output logic sda_o, // Data drive value
    output logic sda_oe // Data pulled low
);
    tws_pkg::tws_state_t state; // Sequencer state
    logic [7:0] ctrl; // Control bits other than flag
    logic [7:0] code; // Status code
    logic [7:0] dreg; // Data register
    logic [2:0] ist; // Sticky events
    logic [2:0] imask; // Event mask
    logic ack; // Bus answer phase
    logic rd_ist; // Pending read of events
    logic [1:0] scl_m, sda_m; // Synchroniser stages, second stage in bit 1
    logic scl_s, sda_s; // Synchronised levels
    logic [5:0] qcnt; // Quarter bit timer
    logic [1:0] ph; // Quarter within a bit
    logic [3:0] bitcnt; // Bit in the current byte
    logic [8:0] sh; // Outgoing bits, ack last
    logic [8:0] rxsh; // Sampled bits, ack last
    logic owned; // Bus is ours
    logic first; // Next byte is the address
    logic rx_mode; // Receiving data bytes
    logic [5:0] free_cnt; // Idle bus timer

    // Bus decode
    wire req = read | write;
    wire rd = read & ack;
    wire wr = write & ack;
    wire wr_ctrl = wr & (address == tws_pkg::OFS_CTRL);
    wire wr_data = wr & (address == tws_pkg::OFS_DATA);
    wire flag = (state == tws_pkg::S_HOLD);
    // Enable written together with the flag clear counts at once
    wire en_now = wr_ctrl ? writedata[tws_pkg::B_EN] : ctrl[tws_pkg::B_EN];
    wire go = wr_ctrl & writedata[tws_pkg::B_FLAG] & en_now;
    wire w_begin = writedata[tws_pkg::B_BEGIN];
    wire w_end = writedata[tws_pkg::B_END];
    wire tick = (qcnt == 6'(tws_pkg::QTR_CYC - 1));
    wire stall = (ph == 2'h2) & ~scl_s;
    wire step = tick & ~stall;
    wire ph_end = step & (ph == 2'h3);
    wire sample = step & (ph == 2'h2) & (state == tws_pkg::S_BIT);
    wire byte_done = ph_end & (state == tws_pkg::S_BIT) & (bitcnt == 4'h8);
    wire is_tx = first | ~rx_mode;
    // drove high but the line reads low
    wire arb_lost = sample & (bitcnt < 4'h8) & is_tx & sh[8] & ~sda_s;
    wire bus_free = (free_cnt == 6'(tws_pkg::FREE_CYC));
    wire [7:0] ctrl_rd = {flag, ctrl[6:0]};
    wire [7:0] rd_mux =
        (address == tws_pkg::OFS_CTRL) ? ctrl_rd :
        (address == tws_pkg::OFS_STAT) ? code :
        (address == tws_pkg::OFS_DATA) ? dreg :
        (address == tws_pkg::OFS_IST) ? {5'h00, ist} :
        (address == tws_pkg::OFS_IMASK) ? {5'h00, imask} : 8'h00;
    wire flag_set_at_end = (state == tws_pkg::S_START) | byte_done;
    // Arbitration loss raises the flag too
    wire [2:0] ev = {arb_lost, wr_data & ~flag,
        (ph_end & flag_set_at_end) | arb_lost};
    wire [8:0] rxn = {rxsh[7:0], sda_s};
    // receive bytes answer with the ack enable bit
    wire [8:0] load = is_tx ? {dreg, 1'b1} :
        {8'hff, ~writedata[tws_pkg::B_ACKEN]};

    // One wait state, then the answer
    assign waitrequest = req & ~ack;
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign irq = ctrl[tws_pkg::B_IRQEN] & |(ist & imask);

    // Answer phase and read data
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ack <= 1'b0;
            readdata <= 8'h00;
            rd_ist <= 1'b0;
        end
        else
        begin
            ack <= req & ~ack;
            // Captured early so it stands at the answer edge
            if (read & ~ack)
                readdata <= rd_mux;
            rd_ist <= read & ~ack & (address == tws_pkg::OFS_IST);
        end
    end

    // Line synchronisers, two stages each
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            scl_m <= 2'h3;
            sda_m <= 2'h3;
        end
        else
        begin
            scl_m <= {scl_m[0], scl_i};
            sda_m <= {sda_m[0], sda_i};
        end
    end
    assign scl_s = scl_m[1];
    assign sda_s = sda_m[1];

    // Events stick; a set in the clearing cycle wins
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ist <= 3'h0;
            imask <= 3'h0;
        end
        else
        begin
            ist <= (ist & ~((rd & rd_ist) ? readdata[2:0] : 3'h0)) | ev;
            if (wr & (address == tws_pkg::OFS_IMASK))
                imask <= writedata[2:0];
        end
    end

    // Bus free when both lines idle long enough
    always_ff @(posedge clk)
    begin
        if (!rst_n || !(scl_s & sda_s))
            free_cnt <= 6'h00;
        else if (!bus_free)
            free_cnt <= free_cnt + 6'h01;
    end

    // Quarter bit timer runs only while the line moves
    always_ff @(posedge clk)
    begin
        if (!rst_n || state == tws_pkg::S_HOLD || state == tws_pkg::S_IDLE)
            qcnt <= 6'h00;
        else if (state == tws_pkg::S_WAIT || tick & ~stall)
            qcnt <= 6'h00;
        else if (!tick)
            qcnt <= qcnt + 6'h01;
    end

    // Control register; flag itself is the hold state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ctrl <= tws_pkg::RST_CTRL;
        else if (wr_ctrl)
            ctrl <= {1'b0, writedata[6:4], ctrl[3], writedata[2:0]};
        // Separate ifs, so a data write cannot swallow the end clear
        else
        begin
            // discarded data write flags a collision
            if (wr_data)
                ctrl[tws_pkg::B_WCOL] <= ~flag;
            if (ph_end & (state == tws_pkg::S_STOP))
                ctrl[tws_pkg::B_END] <= 1'b0;
        end
    end

    // Data register: software byte or received byte
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            dreg <= tws_pkg::RST_DATA;
        else if (wr_data & flag)
            dreg <= writedata;
        // received byte shown when the flag rises
        else if (byte_done & ~is_tx)
            dreg <= rxsh[8:1];
    end

    // Sequencer
    always_ff @(posedge clk)
    begin
        if (!rst_n || !en_now)
        begin
            state <= tws_pkg::S_IDLE;
            code <= tws_pkg::RST_CODE;
            ph <= 2'h0;
            bitcnt <= 4'h0;
            sh <= 9'h1ff;
            rxsh <= 9'h1ff;
            owned <= 1'b0;
            first <= 1'b0;
            rx_mode <= 1'b0;
        end
        else
        begin
            if (step)
                ph <= ph + 2'h1;
            if (sample)
                rxsh <= rxn;
            unique case (state)
                tws_pkg::S_IDLE:
                begin
                    // enable, begin request and flag clear
                    if (go & w_begin & ~w_end)
                        state <= tws_pkg::S_WAIT;
                end
                tws_pkg::S_WAIT:
                begin
                    ph <= 2'h1;
                    if (bus_free)
                        state <= tws_pkg::S_START;
                end
                tws_pkg::S_START:
                begin
                    if (ph_end)
                    begin
                        state <= tws_pkg::S_HOLD;
                        code <= owned ? tws_pkg::C_RSTART :
                            tws_pkg::C_START;
                        owned <= 1'b1;
                        first <= 1'b1;
                    end
                end
                tws_pkg::S_HOLD:
                begin
                    // nothing moves until the flag is cleared
                    if (go)
                    begin
                        ph <= 2'h0;
                        bitcnt <= 4'h0;
                        if (w_end)
                            state <= owned ? tws_pkg::S_STOP :
                                tws_pkg::S_IDLE;
                        else if (w_begin)
                            state <= owned ? tws_pkg::S_START :
                                tws_pkg::S_WAIT;
                        // send the byte and sample ack, or in read mode receive one and send ack
                        else if (owned)
                        begin
                            state <= tws_pkg::S_BIT;
                            sh <= load;
                        end
                        else
                            state <= tws_pkg::S_IDLE;
                    end
                end
                tws_pkg::S_BIT:
                begin
                    if (arb_lost)
                    begin
                        state <= tws_pkg::S_HOLD;
                        code <= tws_pkg::C_ARB;
                        owned <= 1'b0;
                    end
                    else if (ph_end)
                    begin
                        sh <= {sh[7:0], 1'b1};
                        bitcnt <= bitcnt + 4'h1;
                    end
                    if (byte_done & ~arb_lost)
                    begin
                        state <= tws_pkg::S_HOLD;
                        first <= 1'b0;
                        if (first)
                        begin
                            rx_mode <= dreg[0];
                            if (dreg[0])
                                code <= rxsh[0] ? tws_pkg::C_AR_NACK :
                                    tws_pkg::C_AR_ACK;
                            else
                                code <= rxsh[0] ? tws_pkg::C_AW_NACK :
                                    tws_pkg::C_AW_ACK;
                        end
                        else if (!rx_mode)
                            code <= rxsh[0] ? tws_pkg::C_DT_NACK :
                                tws_pkg::C_DT_ACK;
                        else
                            code <= sh[8] ? tws_pkg::C_DR_NACK :
                                tws_pkg::C_DR_ACK;
                    end
                end
                tws_pkg::S_STOP:
                begin
                    if (ph_end)
                    begin
                        owned <= 1'b0;
                        // stop then start on a free bus
                        state <= ctrl[tws_pkg::B_BEGIN] ? tws_pkg::S_WAIT :
                            tws_pkg::S_IDLE;
                    end
                end
                default:
                    state <= tws_pkg::S_IDLE;
            endcase
        end
    end

    // Line drive per state and quarter
    wire scl_low =
        // clock stretched while the flag is up and the bus is ours
        (flag & owned) |
        (state == tws_pkg::S_START &
            ((ph == 2'h0 & owned) | ph == 2'h3)) |
        (state == tws_pkg::S_BIT & ~ph[1]) |
        (state == tws_pkg::S_STOP & ph == 2'h0);
    wire sda_low =
        (state == tws_pkg::S_START & ph[1]) |
        (state == tws_pkg::S_BIT & ~sh[8]) |
        (state == tws_pkg::S_STOP & ~ph[1]);

    // Registered pin enables
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end
        else
        begin
            scl_oe <= scl_low;
            sda_oe <= sda_low;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_start_code;
        state == tws_pkg::S_START && ph_end && !owned
            |=> flag && code == tws_pkg::C_START;
    endproperty
    a_start_code: assert property (p_start_code)
        else $error("start did not give code 08");
    property p_rstart_code;
        state == tws_pkg::S_START && ph_end && owned
            |=> code == tws_pkg::C_RSTART && owned;
    endproperty
    a_rstart_code: assert property (p_rstart_code)
        else $error("repeated start did not give code 10");
    property p_data_code;
        byte_done && !first && !rx_mode && !arb_lost |=>
            code == ($past(rxsh[0]) ? tws_pkg::C_DT_NACK :
            tws_pkg::C_DT_ACK);
    endproperty
    a_data_code: assert property (p_data_code)
        else $error("wrong data byte result code");
    property p_arb;
        arb_lost |=> code == tws_pkg::C_ARB && !owned ##1 !scl_oe;
    endproperty
    a_arb: assert property (p_arb)
        else $error("arbitration loss not handled");
    property p_wcol;
        wr_data && !flag |=> ctrl[tws_pkg::B_WCOL] && dreg == $past(dreg);
    endproperty
    a_wcol: assert property (p_wcol)
        else $error("collision write not discarded");
    property p_hold;
        flag && !go && en_now |=> flag;
    endproperty
    a_hold: assert property (p_hold)
        else $error("transfer moved without flag clear");
    property p_stretch;
        flag && owned ##1 flag |-> scl_oe;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("clock not held low while flag set");
    property p_end_clear;
        ph_end && state == tws_pkg::S_STOP |=> !ctrl[tws_pkg::B_END];
    endproperty
    a_end_clear: assert property (p_end_clear)
        else $error("end request not cleared after stop");
    property p_rx_ack;
        flag && go && owned && !w_begin && !w_end && !is_tx
            |=> sh[0] == !$past(writedata[tws_pkg::B_ACKEN]);
    endproperty
    a_rx_ack: assert property (p_rx_ack)
        else $error("receive ack does not follow ack enable");
    property p_dir;
        byte_done && first && !arb_lost |=> rx_mode == $past(dreg[0]);
    endproperty
    a_dir: assert property (p_dir)
        else $error("mode not taken from direction bit");
    c_rstart: cover property (code == tws_pkg::C_RSTART);
    c_arb: cover property (arb_lost);
    c_rx: cover property (code == tws_pkg::C_DR_ACK);
endmodule : tws_master

// ===== testbench/tws_slave_model.sv
`timescale 1ns/1ns
// Slave on the two-wire bus, watching the lines on the system clock
module tws_slave_model #(
    parameter logic [6:0] OWN_ADDR = 7'h2a // Address we answer
) (
    input wire logic clk, // Sampling clock
    input wire logic scl, // Clock line level
    input wire logic sda, // Data line level
    input wire logic nack_data, // Refuse written bytes
    input wire logic [7:0] tx_byte, // Byte sent on reads
    input wire logic [7:0] stretch, // Clock hold after falls
    output logic sda_oe, // Pull data low
    output logic scl_oe, // Hold clock low
    output logic [7:0] rx_byte, // Last data byte seen on the bus, read or written
    output logic master_ack, // Master's last ack bit
    output logic [7:0] stops // Stop conditions seen
);
    logic p_scl, p_sda, active, addr_ph, rw, match, done, ackd; // State
    logic drv_sda; // Data pull wanted this cycle
    logic [3:0] bits; // Bits of this byte so far
    logic [7:0] sr, txsr, hold; // Shifters and stretch count
    // Idle with both lines released
    initial
    begin
        {drv_sda, sda_oe, scl_oe, active, p_scl, p_sda} = 6'h03;
        stops = 8'h00;
        hold = 8'h00;
    end
    // Conditions and bit timing seen on the lines
    always @(posedge clk)
    begin
        if (scl && p_scl && p_sda && !sda)
        begin
            // Start: address byte follows
            {active, addr_ph, done, ackd, master_ack} = 5'h18;
            bits = 4'h0;
        end
        else if (scl && p_scl && !p_sda && sda)
        begin
            // Stop: frame over
            active = 1'b0;
            stops = stops + 8'h1;
        end
        else if (active && scl && !p_scl)
        begin
            // Rising clock: sample the bit
            if (bits < 4'h8)
                sr = {sr[6:0], sda};
            else if (rw && !addr_ph)
                master_ack = sda;
            ackd = (bits == 4'h8);
            bits = ackd ? 4'h0 : bits + 4'h1;
        end
        else if (active && !scl && p_scl)
        begin
            // Falling clock: drive the next bit, stretch if asked
            hold = stretch;
            drv_sda = 1'b0;
            if (ackd)
            begin
                // A nack from the master ends our sending
                done = done || !match || (rw && master_ack);
                {ackd, addr_ph} = 2'h0;
                txsr = tx_byte;
            end
            if (bits == 4'h8 && addr_ph)
            begin
                match = (sr[7:1] == OWN_ADDR);
                rw = sr[0];
            end
            else if (bits == 4'h8)
                rx_byte = sr;
            if (bits == 4'h8)
                drv_sda = addr_ph ? match : !(rw || done || nack_data);
            else if (rw && !addr_ph && !done)
                drv_sda = !txsr[3'h7 - bits[2:0]];
        end
        // Line drives change by NBA, so no flop races them
        sda_oe <= drv_sda;
        scl_oe <= (hold != 8'h0);
        if (hold != 8'h0)
            hold = hold - 8'h1;
        p_scl = scl;
        p_sda = sda;
    end
endmodule : tws_slave_model

// ===== testbench/tws_master_tb.sv
`timescale 1ns/1ns
// Bench for the two-wire master sequencer
module tws_master_tb;
    localparam logic [6:0] SLV = 7'h2a; // Slave address
    logic clk = 1'b0; // System clock
    logic rst_n = 1'b0; // Reset, active low
    logic [2:0] address = 3'h0; // Register index
    logic read = 1'b0; // Bus read
    logic write = 1'b0; // Bus write
    logic [7:0] writedata = 8'h00; // Bus write data
    logic [7:0] readdata; // Bus read data
    logic waitrequest, irq, scl_o, scl_oe, sda_o, sda_oe; // Design outputs
    logic s_sda_oe, s_scl_oe, m_ack; // Slave drives and master ack seen
    logic [7:0] rx_byte, stops; // Slave observations
    logic nack_data = 1'b0; // Slave refuses data
    logic [7:0] tx_byte = 8'h00; // Slave read byte
    logic [7:0] stretch = 8'h00; // Slave clock hold
    logic rival = 1'b0; // Other master pulling data low
    logic [7:0] rd; // Last read value
    logic [31:0] r; // Random draw
    int seed = 32'h4c977f7e; // Fixed seed
    int miscompares = 0; // Mismatches
    int checks = 0; // Comparisons
    int i; // Loop index
    wire scl_line; // Clock wire
    wire sda_line; // Data wire
    // Open-drain wires with pull-ups
    assign scl_line = !((scl_oe && !scl_o) || s_scl_oe);
    assign sda_line = !((sda_oe && !sda_o) || s_sda_oe || rival);
    // Free-running system clock
    always #50 clk = ~clk;
    tws_master i_dut (.clk(clk), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
        .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe));
    tws_slave_model #(.OWN_ADDR(SLV)) i_slave (.clk(clk), .scl(scl_line),
        .sda(sda_line), .nack_data(nack_data), .tx_byte(tx_byte),
        .stretch(stretch), .sda_oe(s_sda_oe), .scl_oe(s_scl_oe),
        .rx_byte(rx_byte), .master_ack(m_ack), .stops(stops));
    // Counts, verdict, end of run
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run
    // Byte comparison
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check_byte
    // Single-bit comparison
    task automatic check_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check_bit
    // A used-up wait bound ends the run as a failure
    task automatic give_up(input logic hit);
        if (hit)
        begin
            miscompares++;
            $display("Wait limit reached at %0t", $time);
            complete_run();
        end
    endtask : give_up
    // One bus access, held until waitrequest is seen low
    task automatic bus_cycle(input logic we, input logic [2:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= we;
        read <= !we;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
        give_up(n >= 20);
    endtask : bus_cycle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus_cycle(1'b1, a, d);
    endtask : wr
    // Read and compare the bits under a mask
    task automatic rchk(input logic [2:0] a, input logic [7:0] e,
        input logic [7:0] m = 8'hff);
        bus_cycle(1'b0, a, 8'h00);
        check_byte(rd & m, e);
    endtask : rchk
    // Interrupt level, looked at mid-cycle
    task automatic irq_is(input logic e);
        @(negedge clk);
        check_bit(irq, e);
        @(posedge clk);
    endtask : irq_is
    // Wait for the interrupt, then check events and status
    task automatic resume(input logic [7:0] code, input logic [7:0] ev);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 5000)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        give_up(n >= 5000);
        rchk(tws_pkg::OFS_IST, ev);
        rchk(tws_pkg::OFS_STAT, code, 8'hf8);
    endtask : resume
    task automatic step(input logic [7:0] c, input logic [7:0] code,
        input logic [7:0] ev);
        wr(tws_pkg::OFS_CTRL, c);
        resume(code, ev);
    endtask : step
    // Expected transmit status from phase and slave answer
    function automatic logic [7:0] tx_code(input logic adr, input logic nak);
        if (adr)
            return nak ? tws_pkg::C_AW_NACK : tws_pkg::C_AW_ACK;
        return nak ? tws_pkg::C_DT_NACK : tws_pkg::C_DT_ACK;
    endfunction : tx_code
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk(tws_pkg::OFS_CTRL, tws_pkg::RST_CTRL);
        rchk(tws_pkg::OFS_STAT, tws_pkg::RST_CODE);
        rchk(tws_pkg::OFS_DATA, tws_pkg::RST_DATA);
        wr(3'h7, 8'h5a);
        rchk(3'h7, 8'h00);
        wr(tws_pkg::OFS_IMASK, 8'h01);
        rchk(tws_pkg::OFS_IMASK, 8'h01);
        // Collision while idle, masked and then unmasked
        wr(tws_pkg::OFS_CTRL, 8'h05);
        wr(tws_pkg::OFS_DATA, 8'h3c);
        rchk(tws_pkg::OFS_DATA, tws_pkg::RST_DATA);
        rchk(tws_pkg::OFS_CTRL, 8'h0d);
        irq_is(1'b0);
        wr(tws_pkg::OFS_IMASK, 8'h07);
        irq_is(1'b1);
        rchk(tws_pkg::OFS_IST, 8'h02);
        irq_is(1'b0);
        $display("End of register scenario");
        step(8'ha5, tws_pkg::C_START, 8'h01);
        repeat (300) @(posedge clk);
        @(negedge clk);
        check_bit(scl_line, 1'b0);
        @(posedge clk);
        rchk(tws_pkg::OFS_CTRL, 8'h80, 8'h80);
        wr(tws_pkg::OFS_DATA, {SLV, 1'b0});
        rchk(tws_pkg::OFS_CTRL, 8'h00, 8'h08);
        step(8'h85, tx_code(1'b1, 1'b0), 8'h01);
        // Random data bytes, slave answers and stretches at random
        for (i = 0; i < 6; i++)
        begin
            r = $random(seed);
            nack_data <= r[0];
            stretch <= {2'h0, r[13:8]};
            wr(tws_pkg::OFS_DATA, r[23:16]);
            step(8'h85, tx_code(1'b0, r[0]), 8'h01);
            check_byte(rx_byte, r[23:16]);
        end
        $display("End of transmit scenario");
        stretch <= 8'h00;
        tx_byte <= r[31:24];
        step(8'ha5, tws_pkg::C_RSTART, 8'h01);
        wr(tws_pkg::OFS_DATA, {SLV, 1'b1});
        step(8'hc5, tws_pkg::C_AR_ACK, 8'h01);
        // Two acked bytes, then a nacked last one
        for (i = 0; i < 3; i++)
        begin
            step(i < 2 ? 8'hc5 : 8'h85,
                i < 2 ? tws_pkg::C_DR_ACK : tws_pkg::C_DR_NACK, 8'h01);
            rchk(tws_pkg::OFS_DATA, r[31:24]);
            check_bit(m_ack, i == 2);
        end
        wr(tws_pkg::OFS_CTRL, 8'h95);
        rchk(tws_pkg::OFS_CTRL, 8'h10, 8'h10);
        for (i = 0; i < 500 && (rd & 8'h10) != 8'h00; i++)
            rchk(tws_pkg::OFS_CTRL, 8'h00, 8'h00);
        give_up(i >= 500);
        check_byte(stops, 8'h01);
        rchk(tws_pkg::OFS_IST, 8'h00);
        $display("End of receive scenario");
        step(8'ha5, tws_pkg::C_START, 8'h01);
        wr(tws_pkg::OFS_DATA, {7'h11, 1'b1});
        step(8'h85, tws_pkg::C_AR_NACK, 8'h01);
        step(8'hb5, tws_pkg::C_START, 8'h01);
        check_byte(stops, 8'h02);
        rchk(tws_pkg::OFS_CTRL, 8'h00, 8'h10);
        wr(tws_pkg::OFS_DATA, {7'h11, 1'b0});
        step(8'h85, tx_code(1'b1, 1'b1), 8'h01);
        // Another master holds data low and wins the address
        rival <= 1'b1;
        wr(tws_pkg::OFS_DATA, {SLV, 1'b0});
        step(8'h85, tws_pkg::C_ARB, 8'h05);
        wr(tws_pkg::OFS_CTRL, 8'ha5);
        repeat (200) @(posedge clk);
        rchk(tws_pkg::OFS_CTRL, 8'h00, 8'h80);
        rival <= 1'b0;
        resume(tws_pkg::C_START, 8'h01);
        rival <= 1'b1;
        wr(tws_pkg::OFS_DATA, {SLV, 1'b0});
        step(8'h85, tws_pkg::C_ARB, 8'h05);
        wr(tws_pkg::OFS_CTRL, 8'h85);
        repeat (200) @(posedge clk);
        @(negedge clk);
        check_bit(scl_oe || sda_oe, 1'b0);
        @(posedge clk);
        rchk(tws_pkg::OFS_CTRL, 8'h00, 8'h80);
        rival <= 1'b0;
        $display("End of arbitration scenario");
        complete_run();
    end
endmodule : tws_master_tb
